// [cam_capture_asserts.sv]
// checker on the capture unit ports: divider, interrupt, data request
`timescale 1ns/1ps
module cam_capture_asserts
  import cam_capture_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire cam_s        cam,
  input wire logic        camera_clock_out,
  input wire logic        data_request,
  input wire logic        irq
);
  logic [31:0] ctl;
  logic [7:0]  aa;
  logic [4:0]  sc;
  logic [3:0]  hc;
  logic [2:0]  msk;
  logic        aw, q, st, vsa, pop;
  // the divider is judged only once its setting has settled
  assign st  = ctl[CTRL_CLK_EN] && sc == 5'h1F;
  assign vsa = cam.vsync ^ ctl[CTRL_VS_LOW];
  assign pop = hsel && hready && htrans[1] && !hwrite
               && haddr[7:0] == OFS_DATA;
  default clocking dcb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw <= 1'b0;
      aa <= 8'h00;
    end else if (hready) begin
      aw <= hsel && htrans[1] && hwrite;
      aa <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl <= 32'h0;
      msk <= 3'h0;
      sc  <= 5'h00;
    end else begin
      sc <= (sc == 5'h1F) ? sc : sc + 5'h01;
      if (aw && hready && aa == OFS_CTRL) begin
        ctl <= hwdata;
        sc  <= 5'h00;
      end
      if (aw && hready && aa == OFS_MASK) begin
        msk <= hwdata[2:0];
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q  <= 1'b0;
      hc <= 4'h0;
    end else begin
      q  <= camera_clock_out;
      hc <= (camera_clock_out != q) ? 4'h0 : hc + {3'h0, hc != 4'hF};
    end
  end
  chk_div_half: assert property (
    st && camera_clock_out != q |-> hc == {1'b0, ctl[10:8]})
    else $error("camera clock half period wrong");
  chk_div_hold: assert property (
    st |-> hc <= {1'b0, ctl[10:8]})
    else $error("camera clock stopped");
  chk_clk_idle: assert property (
    !ctl[CTRL_CLK_EN] && sc > 5'h03 |-> !camera_clock_out)
    else $error("camera clock runs while disabled");
  chk_irq_masked: assert property (
    msk == 3'h0 && $past(msk) == 3'h0 |-> !irq)
    else $error("irq with all events masked");
  chk_irq_cause: assert property (
    $rose(irq) |-> $past(msk) != 3'h0)
    else $error("irq rose without mask bit");
  chk_req_sync: assert property (
    $rose(data_request) |-> vsa || $past(vsa) || $past(vsa, 2)
      || $past(vsa, 3) || $past(vsa, 4))
    else $error("data word outside a frame");
  chk_req_hold: assert property (
    data_request && !pop |=> data_request)
    else $error("data request dropped without a read");
  chk_ready_up: assert property (
    $past(hresetn) |-> hreadyout)
    else $error("bus not ready");
  chk_resp_okay: assert property (
    hreadyout |-> !hresp)
    else $error("bus response not okay");
endmodule

bind camera_parallel_capture cam_capture_asserts #(.CNT_W(CNT_W)) chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .cam(cam),
  .camera_clock_out(camera_clock_out),
  .data_request(data_request), .irq(irq));

// [cam_capture_pkg.sv]
// shared constants, register map and types of the camera capture unit
package cam_capture_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_HSIZE  = 8'h0C;
  localparam logic [7:0] OFS_VSIZE  = 8'h10;
  localparam logic [7:0] OFS_HOFF   = 8'h14;
  localparam logic [7:0] OFS_VOFF   = 8'h18;
  localparam logic [7:0] OFS_DATA   = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int CTRL_CLK_EN  = 0;
  localparam int CTRL_START   = 1;
  localparam int CTRL_BIG     = 2;
  localparam int CTRL_HS_LOW  = 3;
  localparam int CTRL_VS_LOW  = 4;
  localparam int CTRL_DIV_LSB = 8;
  localparam int DIV_W        = 3;
  localparam int CTRL_BPP_LSB = 12;
  localparam int BPP_W        = 2;

  // status / mask fields: sticky events low, live state above
  localparam int EV_FRAME_END = 0;
  localparam int EV_OVERRUN   = 1;
  localparam int EV_SHORT     = 2;
  localparam int EV_W         = 3;
  localparam int ST_ACTIVE    = 8;
  localparam int ST_FULL      = 9;
  localparam int ST_VSYNC     = 10;
  localparam int ST_HSYNC     = 11;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [DIV_W-1:0] DIV_RST   = 3'h0;
  localparam logic [BPP_W-1:0] BPP_RST   = 2'h1;
  localparam logic [15:0]      HSIZE_RST = 16'h0280;
  localparam logic [15:0]      VSIZE_RST = 16'h01E0;
  localparam logic [15:0]      HOFF_RST  = 16'h0000;
  localparam logic [15:0]      VOFF_RST  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       pclk;
    logic       hsync;
    logic       vsync;
    logic [7:0] data;
  } cam_s;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_ARM   = 3'b010,
    S_FRAME = 3'b100
  } cap_state_e;

endpackage

// [cam_sensor_model.sv]
// behavioural camera: framed pixel stream with its own pixel clock
`timescale 1ns/1ps
module cam_sensor_model
  import cam_capture_pkg::*;
#(
  parameter int HP = 3
) (
  input  wire logic       hclk,
  input  wire logic       run,
  input  wire logic       hs_low,
  input  wire logic       vs_low,
  output cam_s            cam,
  output logic            in_frame,
  output logic [7:0]      frame_no
);
  logic       hs, vs, pc;
  logic [7:0] d;
  assign cam = '{pclk: pc, hsync: hs ^ hs_low, vsync: vs ^ vs_low, data: d};
  // data is meaningless outside a line, so it keeps changing there
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge hclk);
      d <= ~d;
    end
  endtask
  initial begin
    {hs, vs, pc, in_frame} = 4'h0;
    d = 8'h00;
    frame_no = 8'h00;
    forever begin
      idle(30);
      if (run) begin
        vs <= 1'b1;
        in_frame <= 1'b1;
        idle(6);
        for (int l = 0; l < 6; l++) begin
          hs <= 1'b1;
          for (int b = 0; b < 32; b++) begin
            d <= 8'(frame_no * 37 + l * 16 + b);
            repeat (HP) @(posedge hclk);
            pc <= 1'b1;
            repeat (HP) @(posedge hclk);
            pc <= 1'b0;
          end
          idle(1);
          hs <= 1'b0;
          idle(8);
        end
        vs <= 1'b0;
        in_frame <= 1'b0;
        frame_no <= frame_no + 8'h01;
      end
    end
  end
endmodule

// [camera_parallel_capture.sv]
// camera parallel capture unit with AHB-Lite register slave
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

module camera_parallel_capture
  import cam_capture_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire cam_s        cam,
  output logic             camera_clock_out,
  output logic             data_request,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic             clk_en;
  logic             big_endian;
  logic             hs_low;
  logic             vs_low;
  logic [DIV_W-1:0] div_sel;
  logic [BPP_W-1:0] bpp_m1;
  logic [CNT_W-1:0] hsize_r;
  logic [CNT_W-1:0] vsize_r;
  logic [CNT_W-1:0] hoff_r;
  logic [CNT_W-1:0] voff_r;
  logic [EV_W-1:0]  status;
  logic [EV_W-1:0]  mask;

  logic             wr_pend;
  logic [7:0]       wr_addr;
  logic             addr_valid;
  logic             start_req;
  logic             pop;

  logic [DIV_W-1:0] div_cnt;

  cap_state_e       state;
  logic             pclk_d;
  logic             hs_act_d;
  logic             vs_act_d;
  logic             hs_act;
  logic             vs_act;
  logic             pix_rise;
  logic             line_end;
  logic             vs_rise;
  logic             vs_fall;
  logic [CNT_W-1:0] pix_cnt;
  logic [CNT_W-1:0] line_cnt;
  logic [BPP_W-1:0] byte_cnt;
  logic             in_win;
  logic             last_line;
  logic             take_byte;
  logic             frame_done;
  logic             short_frame;

  logic [31:0]      acc;
  logic [1:0]       lane;
  logic [31:0]      next_acc;
  logic             emit;
  logic [31:0]      data_word;
  logic             overrun;
  logic [EV_W-1:0]  ev_set;
  logic [EV_W-1:0]  ev_clr;
  logic [31:0]      rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait state, always OKAY
  assign addr_valid = hsel & hready & htrans[1];
  assign pop        = addr_valid & ~hwrite & (haddr[7:0] == OFS_DATA);
  assign start_req  = wr_pend & (wr_addr == OFS_CTRL) & hwdata[CTRL_START];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= addr_valid & hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_valid) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      OFS_CTRL: begin
        rd_mux[CTRL_CLK_EN]                  = clk_en;
        rd_mux[CTRL_START]                   = (state != S_IDLE);
        rd_mux[CTRL_BIG]                     = big_endian;
        rd_mux[CTRL_HS_LOW]                  = hs_low;
        rd_mux[CTRL_VS_LOW]                  = vs_low;
        rd_mux[CTRL_DIV_LSB +: DIV_W]        = div_sel;
        rd_mux[CTRL_BPP_LSB +: BPP_W]        = bpp_m1;
      end
      OFS_STATUS: begin
        rd_mux[EV_W-1:0]  = status;
        rd_mux[ST_ACTIVE] = (state != S_IDLE);
        rd_mux[ST_FULL]   = data_request;
        rd_mux[ST_VSYNC]  = vs_act;
        rd_mux[ST_HSYNC]  = hs_act;
      end
      OFS_MASK:  rd_mux[EV_W-1:0]  = mask;
      OFS_HSIZE: rd_mux[CNT_W-1:0] = hsize_r;
      OFS_VSIZE: rd_mux[CNT_W-1:0] = vsize_r;
      OFS_HOFF:  rd_mux[CNT_W-1:0] = hoff_r;
      OFS_VOFF:  rd_mux[CNT_W-1:0] = voff_r;
      OFS_DATA:  rd_mux            = data_word;
      default:   rd_mux            = 32'h0000_0000;
    endcase
  end

  // read data is fetched on the address phase edge, so it is the value
  // before any write still sitting in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_valid && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_en     <= 1'b0;
      big_endian <= 1'b0;
      hs_low     <= 1'b0;
      vs_low     <= 1'b0;
      div_sel    <= DIV_RST;
      bpp_m1     <= BPP_RST;
      hsize_r    <= CNT_W'(HSIZE_RST);
      vsize_r    <= CNT_W'(VSIZE_RST);
      hoff_r     <= CNT_W'(HOFF_RST);
      voff_r     <= CNT_W'(VOFF_RST);
      mask       <= '0;
    end else if (wr_pend) begin
      unique case (wr_addr)
        OFS_CTRL: begin
          clk_en     <= hwdata[CTRL_CLK_EN];
          big_endian <= hwdata[CTRL_BIG];
          hs_low     <= hwdata[CTRL_HS_LOW];
          vs_low     <= hwdata[CTRL_VS_LOW];
          div_sel    <= hwdata[CTRL_DIV_LSB +: DIV_W];
          bpp_m1     <= hwdata[CTRL_BPP_LSB +: BPP_W];
        end
        OFS_MASK:  mask    <= hwdata[EV_W-1:0];
        OFS_HSIZE: hsize_r <= hwdata[CNT_W-1:0];
        OFS_VSIZE: vsize_r <= hwdata[CNT_W-1:0];
        OFS_HOFF:  hoff_r  <= hwdata[CNT_W-1:0];
        OFS_VOFF:  voff_r  <= hwdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // camera clock: half period of div_sel+1 bus clocks, ratio 2..16
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt          <= '0;
      camera_clock_out <= 1'b0;
    end else if (!clk_en) begin
      div_cnt          <= '0;
      camera_clock_out <= 1'b0;
    end else if (div_cnt >= div_sel) begin
      // runs independent of capture so the sensor can be set up first
      div_cnt          <= '0;
      camera_clock_out <= ~camera_clock_out;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync and pixel clock edge detection; inputs are synchronous to hclk,
  // which is why the pixel clock has to stay well under the bus clock
  assign hs_act   = cam.hsync ^ hs_low;
  assign vs_act   = cam.vsync ^ vs_low;
  assign pix_rise = cam.pclk & ~pclk_d;
  assign line_end = hs_act_d & ~hs_act;
  assign vs_rise  = vs_act & ~vs_act_d;
  assign vs_fall  = vs_act_d & ~vs_act;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pclk_d   <= 1'b0;
      hs_act_d <= 1'b0;
      vs_act_d <= 1'b0;
    end else begin
      pclk_d   <= cam.pclk;
      hs_act_d <= hs_act;
      vs_act_d <= vs_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture window
  assign in_win = ({1'b0, pix_cnt} >= {1'b0, hoff_r}) &&
                  ({1'b0, pix_cnt} < ({1'b0, hoff_r} + {1'b0, hsize_r})) &&
                  ({1'b0, line_cnt} >= {1'b0, voff_r}) &&
                  ({1'b0, line_cnt} < ({1'b0, voff_r} + {1'b0, vsize_r}));
  assign last_line = (({1'b0, line_cnt} + 1'b1) ==
                      ({1'b0, voff_r} + {1'b0, vsize_r}));

  // bytes are only taken inside the window, on pixel clock edges
  assign take_byte   = (state == S_FRAME) & pix_rise & hs_act & vs_act &
                       in_win;
  assign frame_done  = (state == S_FRAME) & line_end & last_line;
  assign short_frame = (state == S_FRAME) & vs_fall & ~frame_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE:  if (start_req) state <= S_ARM;
        S_ARM:   if (vs_rise) state <= S_FRAME;
        S_FRAME: if (frame_done || short_frame) state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pix_cnt  <= '0;
      line_cnt <= '0;
      byte_cnt <= '0;
    end else if (state != S_FRAME) begin
      pix_cnt  <= '0;
      line_cnt <= '0;
      byte_cnt <= '0;
    end else if (line_end) begin
      pix_cnt  <= '0;
      byte_cnt <= '0;
      line_cnt <= line_cnt + 1'b1;
    end else if (pix_rise && hs_act && vs_act) begin
      if (byte_cnt == bpp_m1) begin
        byte_cnt <= '0;
        pix_cnt  <= pix_cnt + 1'b1;
      end else begin
        byte_cnt <= byte_cnt + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte packing into words; a partial last word is flushed at frame end
  always_comb begin
    next_acc = acc;
    if (take_byte) begin
      if (big_endian) begin
        next_acc[(3 - lane) * 8 +: 8] = cam.data;
      end else begin
        next_acc[lane * 8 +: 8] = cam.data;
      end
    end
  end

  assign emit = (take_byte && lane == 2'h3) ||
                (frame_done && lane != 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc  <= 32'h0000_0000;
      lane <= 2'h0;
    end else if (emit || state != S_FRAME) begin
      acc  <= 32'h0000_0000;
      lane <= 2'h0;
    end else if (take_byte) begin
      acc  <= next_acc;
      lane <= lane + 1'b1;
    end
  end

  // single holding word; the drain side must empty it before the next
  // word completes, a new word arriving while full is dropped
  assign overrun = emit & data_request & ~pop;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_word    <= 32'h0000_0000;
      data_request <= 1'b0;
    end else if (emit && !overrun) begin
      data_word    <= next_acc;
      data_request <= 1'b1;
    end else if (pop) begin
      data_request <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear; a set in the clear cycle wins
  always_comb begin
    ev_set               = '0;
    ev_set[EV_FRAME_END] = frame_done;
    ev_set[EV_OVERRUN]   = overrun;
    ev_set[EV_SHORT]     = short_frame;
    ev_clr               = '0;
    if (wr_pend && wr_addr == OFS_STATUS) begin
      ev_clr = hwdata[EV_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

endmodule

// [tb_top.sv]
// self-checking bench: register defaults, divider, windowed capture
`timescale 1ns/1ps
module tb_top;
  import cam_capture_pkg::*;
  localparam logic [31:0] RST_EXP [8] = '{{18'h0, BPP_RST, 1'b0, DIV_RST,
    8'h00}, 32'h0, 32'h0, {16'h0, HSIZE_RST}, {16'h0, VSIZE_RST},
    {16'h0, HOFF_RST}, {16'h0, VOFF_RST}, 32'h0};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, ccko, dreq, irq;
  logic        run, hs_low, vs_low, in_frame;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  frame_no;
  cam_s        cam;
  int          num_errors, cmp_count, seed;
  always #5 hclk = ~hclk;
  camera_parallel_capture #(.CNT_W(16)) uut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .cam(cam),
    .camera_clock_out(ccko), .data_request(dreq), .irq(irq));
  cam_sensor_model #(.HP(3)) sensor (.hclk(hclk), .run(run),
    .hs_low(hs_low), .vs_low(vs_low), .cam(cam), .in_frame(in_frame),
    .frame_no(frame_no));
  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    num_errors++;
    $display("BAD %0t wait ran out", $time);
    finish_test();
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
    rd = hrdata;
    if (n >= 99) hang();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic await(ref logic s, input logic val, input int lim);
    for (int n = 0; s !== val; n++) begin
      if (n > lim) hang();
      @(posedge hclk);
    end
  endtask
  function automatic logic [7:0] px(int f, int l, int b);
    return 8'(f * 37 + l * 16 + b);
  endfunction
  // one windowed frame; f picks polarity, order, bytes per pixel, mask
  task automatic frame(input int f);
    int w, h, ho, vo, bp, fn, nb, i, k;
    logic big, ovr;
    logic [2:0] m;
    logic [31:0] v, e;
    ovr = (f == 4);
    // three and four byte pixels need a narrow window to fit in a line
    w = ovr ? 12 : (f > 1) ? 4 : 4 * (1 + {$random(seed)} % 3);
    h = 2 + {$random(seed)} % 3;
    ho = {$random(seed)} % 4;
    vo = {$random(seed)} % 2;
    bp = ovr ? 1 : 1 + f % 4;
    big = f[2] ^ f[0];
    m = (f == 1) ? 3'h0 : 3'h3;
    hs_low <= f[0];
    vs_low <= f[1];
    wr(OFS_HSIZE, 32'(w));
    wr(OFS_VSIZE, 32'(h));
    wr(OFS_HOFF, 32'(ho));
    wr(OFS_VOFF, 32'(vo));
    wr(OFS_MASK, {29'h0, m});
    v = 32'h1 | 32'(big) << CTRL_BIG | 32'(f[0]) << CTRL_HS_LOW
      | 32'(f[1]) << CTRL_VS_LOW | 32'(bp - 1) << CTRL_BPP_LSB;
    wr(OFS_CTRL, v);
    await(in_frame, 1'b0, 3000);
    await(in_frame, 1'b1, 3000);
    repeat (20) @(posedge hclk);
    // started mid-frame, so the following frame is the one taken
    fn = frame_no + 1;
    wr(OFS_CTRL, v | 32'h2);
    nb = w * h * bp;
    for (i = 0; i < nb; i += 4) begin
      for (int j = 0; j < 4; j++) begin
        k = i + j;
        e = big ? {e[23:0], px(fn, vo + k / (w * bp), ho * bp + k % (w * bp))}
                : {px(fn, vo + k / (w * bp), ho * bp + k % (w * bp)), e[31:8]};
      end
      if (!ovr || i == 0) begin
        await(dreq, 1'b1, 3000);
        bus(1'b0, OFS_DATA, 32'h0, v);
        chk(v, e);
      end
    end
    i = 0;
    do begin
      bus(1'b0, OFS_STATUS, 32'h0, v);
      i++;
    end while (v[EV_FRAME_END] !== 1'b1 && i < 400);
    if (i >= 400) hang();
    chk(v & 32'h7, ovr ? 32'h3 : 32'h1);
    chk({31'h0, irq}, {31'h0, m != 3'h0});
    wr(OFS_STATUS, 32'h7);
    if (ovr) bus(1'b0, OFS_DATA, 32'h0, v);
    bus(1'b0, OFS_STATUS, 32'h0, v);
    chk({27'h0, v[2:0], irq, dreq}, 32'h0);
    $display("test frame %0d done", f);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic q;
    int t;
    {hclk, hresetn, hsel, hwrite, run, hs_low, vs_low} = 7'h0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    seed = 87664;
    num_errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, i < 7 ? 8'(4 * i) : 8'h30, 32'h0, v);
      chk(v, RST_EXP[i]);
    end
    $display("test register defaults done");
    for (int d = 0; d < 8; d++) begin
      wr(OFS_CTRL, 32'h1001 | 32'(d) << CTRL_DIV_LSB);
      repeat (40) @(posedge hclk);
      t = 0;
      q = ccko;
      repeat (16 * (d + 1)) begin
        @(posedge hclk);
        t += int'(ccko !== q);
        q = ccko;
      end
      chk(32'(t), 32'd16);
    end
    wr(OFS_CTRL, 32'h0);
    repeat (20) @(posedge hclk);
    chk({31'h0, ccko}, 32'h0);
    $display("test clock divider done");
    run <= 1'b1;
    for (int f = 0; f < 5; f++) frame(f);
    // window taller than the sensor frame: frame sync ends it early
    wr(OFS_HSIZE, 32'h0);
    wr(OFS_VSIZE, 32'h8);
    wr(OFS_MASK, 32'h4);
    wr(OFS_CTRL, 32'h3);
    await(irq, 1'b1, 6000);
    bus(1'b0, OFS_STATUS, 32'h0, v);
    chk(v & 32'h107, 32'h4);
    $display("test short frame done");
    finish_test();
  end
endmodule
